// File: verilog/sfp_regs.vh
// Constants for the serial flash page program sequencer
`ifndef SFP_REGS_VH
`define SFP_REGS_VH

// ********************************
// Opcodes
// ********************************
`define SFP_OP_PROG_SINGLE 8'h02
`define SFP_OP_PROG_DUAL   8'ha2
`define SFP_OP_READ_STATUS 8'h05
`define SFP_OP_ACTIVE_STAT 8'h25

// ********************************
// Frame layout, in serial clock edges
// ********************************
`define SFP_OPC_EDGES  6'h08
`define SFP_HDR_EDGES  6'h20
`define SFP_ASI_EDGES  6'h10

// ********************************
// Status byte field positions
// ********************************
`define SFP_ST_BUSY 0
`define SFP_ST_WEL  1
`define SFP_ST_EPE  5

// ********************************
// Erased byte and reset values
// ********************************
`define SFP_ERASED_BYTE 8'hff
`define SFP_WEL_RESET   1'b0
`define SFP_EPE_RESET   1'b0

// ********************************
// Timing
// ********************************
`define SFP_CLK_PERIOD_NS   5
`define SFP_PAGE_PROG_US    3000
`define SFP_BYTE_PROG_US    100
`define SFP_PAGE_PROG_CYC   (`SFP_PAGE_PROG_US * 1000 / `SFP_CLK_PERIOD_NS)
`define SFP_BYTE_PROG_CYC   (`SFP_BYTE_PROG_US * 1000 / `SFP_CLK_PERIOD_NS)

`endif

// File: verilog/sfp_fifo.v
// Small synchronous FIFO carrying captured bytes to the page buffer
`timescale 1ns/100ps
`default_nettype none

module sfp_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             sys_clk,
  input  wire             rst,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_q;
  reg [AW-1:0]    rdPtr_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  // ********************************
  // Flags
  // ********************************
  assign inReady  = (cnt_q != DEPTH[AW:0]);
  assign outValid = (cnt_q != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr_q];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // Pointers wrap naturally when depth is a power of two
  always @(posedge sys_clk) begin
    if (rst) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      cnt_q   <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // Storage has no reset; flags guard every read
  always @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

endmodule // sfp_fifo

`default_nettype wire

// File: verilog/sfp_page_program.v
// Byte/page program command handler of a serial flash, single and dual input
//
// Notes on behaviour
// - Programming only clears bits; a byte is erased when it reads all ones.
// - Program commands need the write enable latch set, else refused.
// - Opcode 02h, three address bytes, then data bytes go to the page buffer.
// - Opcode A2h, three address bytes, then data two bits per clock.
// - Dual data MSB first: bit7 on SO, bit6 on SI; four clocks per byte.
// - Buffer index comes from low address byte and wraps inside the page.
// - Beyond a full page only the latest 256 bytes stay buffered.
// - At chip select release only buffered bytes are programmed; rest untouched.
// - Full address, one whole byte and byte-aligned release, else abort.
// - Protected target: skip programming, return idle at chip select release.
// - Any abort clears the write enable latch.
// - Status reads show busy while programming runs.
// - Programming is self-timed: page time, or byte time for one byte.
// - Active status interrupt drives SO low as soon as busy ends.
// - Write enable latch clears before a successful program finishes.
// - Internal verify sets the program error flag on a failed byte.
`timescale 1ns/100ps
`default_nettype none
`include "sfp_regs.vh"

module sfp_page_program #(
  parameter PAGE_PROG_CYCLES = `SFP_PAGE_PROG_CYC,
  parameter BYTE_PROG_CYCLES = `SFP_BYTE_PROG_CYC
) (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        spiCsN,
  input  wire        spiSck,
  input  wire        spiSi,
  input  wire        spiSoIn,
  output reg         spiSoOut,
  output reg         spiSoOe,
  input  wire        welSet,
  input  wire        welClr,
  input  wire [7:0]  sectorProtect,
  output reg  [23:0] arrayAddr,
  output reg  [7:0]  arrayWrData,
  output reg         arrayWrEn,
  input  wire [7:0]  arrayRdData,
  output reg         writeEnableLatch,
  output reg         progBusy,
  output reg         eraseProgramErrorFlag
);

  // ********************************
  // States
  // ********************************
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_DRAIN = 3'd1;
  localparam [2:0] ST_RD    = 3'd2;
  localparam [2:0] ST_WR    = 3'd3;
  localparam [2:0] ST_HOLD  = 3'd4;
  localparam [2:0] ST_VF    = 3'd5;
  localparam [2:0] ST_TIME  = 3'd6;

  // Byte assembled at the end of a data slot, single or dual
  function [7:0] asmByte;
    input       dual;
    input [7:0] sh;
    input       so;
    input       si;
    begin
      asmByte = dual ? {sh[5:0], so, si} : {sh[6:0], si};
    end
  endfunction

  // ********************************
  // Pin synchronisers
  // ********************************
  reg [3:0] pinS1_q;
  reg [3:0] pinS2_q;
  reg       sckP_q;
  reg       csP_q;
  wire      csNS    = pinS2_q[0];
  wire      sckS    = pinS2_q[1];
  wire      siS     = pinS2_q[2];
  wire      soS     = pinS2_q[3];
  wire      csFall  = csP_q & ~csNS;
  wire      csRise  = ~csP_q & csNS;
  wire      sckRise = ~csNS & sckS & ~sckP_q;
  wire      sckFall = ~csNS & ~sckS & sckP_q;

  // Two flops on every pin; the second flop alone feeds logic
  always @(posedge sys_clk) begin
    if (rst) begin
      pinS1_q <= 4'h1;
      pinS2_q <= 4'h1;
      sckP_q  <= 1'b0;
      csP_q   <= 1'b1;
    end else begin
      pinS1_q <= {spiSoIn, spiSi, spiSck, spiCsN};
      pinS2_q <= pinS1_q;
      sckP_q  <= sckS;
      csP_q   <= csNS;
    end
  end

  // ********************************
  // Frame capture
  // ********************************
  reg [2:0]  st_q;
  reg [5:0]  hdrCnt_q;
  reg [31:0] hdrSh_q;
  reg [7:0]  opc_q;
  reg [23:0] addr_q;
  reg [7:0]  dSh_q;
  reg [2:0]  bitPh_q;
  reg [8:0]  nBytes_q;
  reg [7:0]  wrIdx_q;
  reg        frameOk_q;
  reg        ovf_q;
  reg [7:0]  stSh_q;
  wire       isDual   = (opc_q == `SFP_OP_PROG_DUAL);
  wire       isProg   = frameOk_q & (isDual | (opc_q == `SFP_OP_PROG_SINGLE));
  wire       inData   = isProg & (hdrCnt_q == `SFP_HDR_EDGES);
  wire       byteDone = inData & sckRise & (bitPh_q == (isDual ? 3'd6 : 3'd7));
  wire [7:0] newByte  = asmByte(isDual, dSh_q, soS, siS);
  wire       busy     = (st_q != ST_IDLE) & (st_q != ST_DRAIN);
  wire       fifoInRdy;
  wire       fifoOutVal;
  wire [15:0] fifoOut;
  wire       pushByte = byteDone & fifoInRdy;

  // Opcode, address and data shifting on rising SCK
  always @(posedge sys_clk) begin
    if (rst) begin
      hdrCnt_q  <= 6'h00;
      hdrSh_q   <= 32'h0000_0000;
      opc_q     <= 8'h00;
      addr_q    <= 24'h00_0000;
      dSh_q     <= 8'h00;
      bitPh_q   <= 3'd0;
      nBytes_q  <= 9'h000;
      wrIdx_q   <= 8'h00;
      frameOk_q <= 1'b0;
      ovf_q     <= 1'b0;
    end else if (csFall) begin
      hdrCnt_q  <= 6'h00;
      opc_q     <= 8'h00;
      bitPh_q   <= 3'd0;
      nBytes_q  <= 9'h000;
      ovf_q     <= 1'b0;
      frameOk_q <= (st_q == ST_IDLE);   // Program frames outside ST_IDLE are ignored
    end else if (sckRise) begin
      if (hdrCnt_q != `SFP_HDR_EDGES) begin
        hdrSh_q  <= {hdrSh_q[30:0], siS};
        hdrCnt_q <= hdrCnt_q + 6'h01;
        if (hdrCnt_q == `SFP_OPC_EDGES - 6'h01) begin
          opc_q <= {hdrSh_q[6:0], siS};
        end
        // Frames during busy must not move the address under the walk
        if ((hdrCnt_q == `SFP_HDR_EDGES - 6'h01) & frameOk_q) begin
          addr_q  <= {hdrSh_q[22:0], siS};
          wrIdx_q <= {hdrSh_q[6:0], siS};
        end
      end else if (inData) begin
        if (isDual) begin
          dSh_q   <= {dSh_q[5:0], soS, siS};
          bitPh_q <= bitPh_q + 3'd2;
        end else begin
          dSh_q   <= {dSh_q[6:0], siS};
          bitPh_q <= bitPh_q + 3'd1;
        end
        if (byteDone) begin
          wrIdx_q  <= wrIdx_q + 8'h01;
          nBytes_q <= nBytes_q[8] ? nBytes_q : nBytes_q + 9'h001;
          ovf_q    <= ovf_q | ~fifoInRdy;
        end
      end
    end
  end

  // ********************************
  // Byte FIFO and page buffer
  // ********************************
  sfp_fifo #(
    .WIDTH (16),
    .DEPTH (4),
    .AW    (2)
  ) uFifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .inValid  (pushByte),
    .inReady  (fifoInRdy),
    .inData   ({wrIdx_q, newByte}),
    .outValid (fifoOutVal),
    .outReady (st_q == ST_DRAIN || st_q == ST_IDLE),
    .outData  (fifoOut)
  );

  reg [7:0]   pageBuf [0:255];
  reg [255:0] bufVal_q;
  reg [7:0]   bufRd_q;
  reg [7:0]   idx_q;
  wire        drain = fifoOutVal & ((st_q == ST_DRAIN) | (st_q == ST_IDLE));

  // Later bytes overwrite earlier ones at the same index
  always @(posedge sys_clk) begin
    if (drain) begin
      pageBuf[fifoOut[15:8]] <= fifoOut[7:0];
    end
    bufRd_q <= pageBuf[idx_q];
  end

  // Which page slots actually received data
  always @(posedge sys_clk) begin
    if (rst) begin
      bufVal_q <= {256{1'b0}};
    end else if (csFall & (st_q == ST_IDLE)) begin
      bufVal_q <= {256{1'b0}};
    end else if (drain) begin
      bufVal_q[fifoOut[15:8]] <= 1'b1;
    end
  end

  // ********************************
  // Program sequencer
  // ********************************
  reg [19:0] tmr_q;
  wire       hdrBad  = (hdrCnt_q != `SFP_HDR_EDGES) | (nBytes_q == 9'h000);
  wire       aborted = hdrBad | (bitPh_q != 3'd0) | ovf_q;
  wire       protHit = sectorProtect[addr_q[18:16]];
  wire       tmrDone = (tmr_q == 20'h0_0000);

  // Walks the page, programs buffered slots, verifies, then times out
  always @(posedge sys_clk) begin
    if (rst) begin
      st_q                  <= ST_IDLE;
      idx_q                 <= 8'h00;
      tmr_q                 <= 20'h0_0000;
      arrayAddr             <= 24'h00_0000;
      arrayWrData           <= `SFP_ERASED_BYTE;
      arrayWrEn             <= 1'b0;
      writeEnableLatch      <= `SFP_WEL_RESET;
      eraseProgramErrorFlag <= `SFP_EPE_RESET;
    end else begin
      if (!tmrDone) begin
        tmr_q <= tmr_q - 20'h0_0001;
      end
      if (welSet & (st_q == ST_IDLE)) begin
        writeEnableLatch <= 1'b1;
      end else if (welClr) begin
        writeEnableLatch <= 1'b0;
      end
      case (st_q)
        ST_IDLE: begin
          if (csRise & isProg) begin
            st_q <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (!fifoOutVal) begin
            if (!writeEnableLatch) begin
              st_q <= ST_IDLE;
            end else if (aborted | protHit) begin
              writeEnableLatch <= 1'b0;
              st_q             <= ST_IDLE;
            end else begin
              writeEnableLatch      <= 1'b0;
              eraseProgramErrorFlag <= 1'b0;
              idx_q                 <= 8'h00;
              tmr_q                 <= (nBytes_q == 9'h001) ?
                                       BYTE_PROG_CYCLES[19:0] :
                                       PAGE_PROG_CYCLES[19:0];
              st_q                  <= ST_RD;
            end
          end
        end
        ST_RD: begin
          if (bufVal_q[idx_q]) begin
            arrayAddr <= {addr_q[23:8], idx_q};
            st_q      <= ST_WR;
          end else if (idx_q == 8'hff) begin
            st_q <= ST_TIME;
          end else begin
            idx_q <= idx_q + 8'h01;
          end
        end
        ST_WR: begin
          arrayWrData <= arrayRdData & bufRd_q;
          arrayWrEn   <= 1'b1;
          st_q        <= ST_HOLD;
        end
        ST_HOLD: begin
          arrayWrEn <= 1'b0;
          st_q      <= ST_VF;
        end
        ST_VF: begin
          if (arrayRdData != bufRd_q) begin
            eraseProgramErrorFlag <= 1'b1;
          end
          if (idx_q == 8'hff) begin
            st_q <= ST_TIME;
          end else begin
            idx_q <= idx_q + 8'h01;
            st_q  <= ST_RD;
          end
        end
        ST_TIME: begin
          if (tmrDone) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ********************************
  // Status output on SO
  // ********************************
  wire [7:0] statusByte = ({7'h00, busy} << `SFP_ST_BUSY) |
                          ({7'h00, writeEnableLatch} << `SFP_ST_WEL) |
                          ({7'h00, eraseProgramErrorFlag} << `SFP_ST_EPE);
  wire       isStat = (opc_q == `SFP_OP_READ_STATUS);
  wire       isAsi  = (opc_q == `SFP_OP_ACTIVE_STAT) & (hdrCnt_q >= `SFP_ASI_EDGES);

  // Status read shifts out on falling SCK; active status needs no clock after its first 16 edges
  always @(posedge sys_clk) begin
    if (rst) begin
      spiSoOut <= 1'b0;
      spiSoOe  <= 1'b0;
      stSh_q   <= 8'h00;
      progBusy <= 1'b0;
    end else begin
      progBusy <= busy;
      if (csNS) begin
        spiSoOe <= 1'b0;
      end else if (isAsi) begin
        spiSoOe  <= 1'b1;
        spiSoOut <= busy;
      end else if (isStat & sckFall) begin
        spiSoOe  <= 1'b1;
        spiSoOut <= stSh_q[7];
        stSh_q   <= {stSh_q[6:0], stSh_q[7]};
      end
      if (sckRise & (hdrCnt_q == `SFP_OPC_EDGES - 6'h01)) begin
        stSh_q <= statusByte;
      end
    end
  end

endmodule // sfp_page_program

`default_nettype wire

// File: verif/sfp_pp_monitor.sv
// Concurrent checks on the page program sequencer ports
`timescale 1ns/100ps
`default_nettype none
module sfp_pp_monitor #(
  parameter int PAGE_PROG_CYCLES = 600000,
  parameter int BYTE_PROG_CYCLES = 20000
) (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        spiCsN,
  input wire logic        spiSck,
  input wire logic        spiSi,
  input wire logic        spiSoIn,
  input wire logic        spiSoOut,
  input wire logic        spiSoOe,
  input wire logic        welSet,
  input wire logic        welClr,
  input wire logic [7:0]  sectorProtect,
  input wire logic [23:0] arrayAddr,
  input wire logic [7:0]  arrayWrData,
  input wire logic        arrayWrEn,
  input wire logic [7:0]  arrayRdData,
  input wire logic        writeEnableLatch,
  input wire logic        progBusy,
  input wire logic        eraseProgramErrorFlag
);
  logic welSeen_q;
  int   busyCnt_q;
  // ****
  // Helpers
  // ****
  // Latch seen since last launch; length of the busy run
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      welSeen_q <= 1'h0;
      busyCnt_q <= 0;
    end else begin
      welSeen_q <= writeEnableLatch | (welSeen_q & ~progBusy);
      busyCnt_q <= progBusy ? busyCnt_q + 1 : 0;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ****
  // Checks
  // ****
  launch_wel_a: assert property ($rose(progBusy) |-> welSeen_q)
    else $error("launch without latch");
  wel_drop_a: assert property ($rose(progBusy) |-> ##[0:2] !writeEnableLatch)
    else $error("latch not cleared");
  write_busy_a: assert property (arrayWrEn |-> progBusy)
    else $error("write while idle");
  write_pulse_a: assert property (arrayWrEn |=> !arrayWrEn [*2])
    else $error("write pulse too long");
  only_clear_a: assert property (arrayWrEn |-> (arrayWrData & ~arrayRdData) == 8'h00)
    else $error("write sets a bit");
  addr_held_a: assert property (arrayWrEn |-> $stable(arrayAddr))
    else $error("address moved at write");
  busy_bound_a: assert property (progBusy |-> busyCnt_q <= PAGE_PROG_CYCLES + 16)
    else $error("busy too long");
  err_busy_a: assert property ($rose(eraseProgramErrorFlag) |-> progBusy)
    else $error("error flag outside program");
endmodule // sfp_pp_monitor
bind sfp_page_program sfp_pp_monitor #(
  .PAGE_PROG_CYCLES(PAGE_PROG_CYCLES), .BYTE_PROG_CYCLES(BYTE_PROG_CYCLES)
) u_mon (
  .sys_clk(sys_clk), .rst(rst), .spiCsN(spiCsN), .spiSck(spiSck), .spiSi(spiSi),
  .spiSoIn(spiSoIn), .spiSoOut(spiSoOut), .spiSoOe(spiSoOe), .welSet(welSet),
  .welClr(welClr), .sectorProtect(sectorProtect), .arrayAddr(arrayAddr),
  .arrayWrData(arrayWrData), .arrayWrEn(arrayWrEn), .arrayRdData(arrayRdData),
  .writeEnableLatch(writeEnableLatch), .progBusy(progBusy),
  .eraseProgramErrorFlag(eraseProgramErrorFlag)
);
`default_nettype wire

// File: verif/sfp_host_model.sv
// SPI host model issuing program, status and active status frames
`timescale 1ns/100ps
`default_nettype none
module sfp_host_model (
  output var logic  csN,
  output var logic  sck,
  output var logic  si,
  output wire logic soIn,
  input  wire logic soOut,
  input  wire logic soOe
);
  logic       hOe = 1'h0;
  logic       hSo = 1'h0;
  logic [7:0] rx = 8'h00;
  int         cnt = 0;
  int         lim = -1;
  // Released SO shows the inverse of its last level, never a stale copy
  assign soIn = soOe ? soOut : (hOe ? hSo : ~soOut);
  // Idle pins; the serial clock stands still between frames
  initial begin
    csN = 1'h1;
    sck = 1'h0;
    si = 1'h0;
  end
  // One clock: data set while low, sampled on the rise
  task automatic pulse(input logic a, input logic b);
    if (cnt != lim) begin
      hSo = a;
      si = b;
      #24 sck = 1'h1;
      rx = {rx[6:0], soIn};
      #24 sck = 1'h0;
      cnt++;
    end
  endtask
  task automatic start();
    cnt = 0;
    csN = 1'h0;
    #24;
  endtask
  task automatic stop();
    #24 csN = 1'h1;
    hOe = 1'h0;
    si = ~si;
    lim = -1;
    #96;
  endtask
  // Opcode then spare clocks; select stays low for the caller
  task automatic cmd(input logic [7:0] opc, input int n);
    start();
    for (int i = 0; i < n; i++) pulse(1'h0, i < 8 ? opc[7 - i] : 1'h0);
  endtask
  // Header MSB first, then data bytes seed+k+k/256 so a second pass differs
  // from the first; cut stops after that many clocks
  task automatic frame(input logic [7:0] opc, input logic [23:0] adr,
                       input int n, input logic [7:0] seed, input int cut);
    logic [31:0] h;
    logic [7:0]  b;
    h = {opc, adr};
    lim = cut;
    start();
    for (int i = 31; i >= 0; i--) pulse(1'h0, h[i]);
    hOe = (opc == 8'ha2);
    for (int k = 0; k < n; k++) begin
      b = seed + 8'(k) + 8'(k >> 8);
      if (hOe) for (int j = 7; j > 0; j -= 2) pulse(b[j], b[j - 1]);
      else for (int j = 7; j >= 0; j--) pulse(1'h0, b[j]);
    end
    stop();
  endtask
endmodule // sfp_host_model
`default_nettype wire

// File: verif/test_spi_flash_page_program.sv
// Self-checking bench for the page program sequencer
`timescale 1ns/100ps
`default_nettype none
module test_spi_flash_page_program;
  localparam int PP = 2000;
  localparam int BP = 400; // Above the 259-cycle walk of a single-byte program
  typedef struct {
    logic [7:0] opc; logic [23:0] adr; int n; int cut; logic wl; logic [7:0] pr; logic ok;
  } sfp_row_t;
  logic        clk, rst, csN, sck, si, soIn, soOut, soOe, welSet, welClr, aWe, write_enable_latch, busy, err;
  logic [7:0]  prot, aWd, aRd, ep [0:255], mem [0:8191];
  logic [23:0] aAddr;
  int          fails = 0, comparisons = 0, bsy = 0, p;
  sfp_row_t    r, rows [0:8];
  // Clock at 5 ns
  initial clk = 1'h0;
  always #2.5 clk = ~clk;
  function automatic int idx(input logic [23:0] a);
    return {a[18:16], a[9:0]};
  endfunction
  // Array model and busy length count
  assign aRd = mem[idx(aAddr)];
  always @(posedge clk) begin
    if (aWe) mem[idx(aAddr)] <= aWd;
    if (busy) bsy <= bsy + 1;
  end
  sfp_page_program #(.PAGE_PROG_CYCLES(PP), .BYTE_PROG_CYCLES(BP)) u_dut (
    .sys_clk(clk), .rst(rst), .spiCsN(csN), .spiSck(sck), .spiSi(si), .spiSoIn(soIn),
    .spiSoOut(soOut), .spiSoOe(soOe), .welSet(welSet), .welClr(welClr),
    .sectorProtect(prot), .arrayAddr(aAddr), .arrayWrData(aWd), .arrayWrEn(aWe),
    .arrayRdData(aRd), .writeEnableLatch(write_enable_latch), .progBusy(busy), .eraseProgramErrorFlag(err)
  );
  sfp_host_model u_host (
    .csN(csN), .sck(sck), .si(si), .soIn(soIn), .soOut(soOut), .soOe(soOe)
  );
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_wel();
    welSet = 1'h1;
    step(1);
    welSet = 1'h0;
    step(4);
  endtask
  // Bounded wait for the program to finish
  task automatic settle();
    step(20);
    for (int t = 0; t < 3000 && busy !== 1'h0; t++) step(1);
  endtask
  task automatic final_report();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog well past the longest expected run
  initial begin
    #500000;
    fails++;
    final_report();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    {rst, welSet, welClr} = 3'h4;
    prot = 8'h00;
    for (int k = 0; k < 8192; k++) mem[k] = 8'hff;
    rows = '{'{8'h02, 24'h0000fe, 3, -1, 1, 0, 1}, '{8'ha2, 24'h010005, 2, -1, 1, 0, 1},
             '{8'h02, 24'h020010, 1, -1, 1, 0, 1}, '{8'ha2, 24'h030000, 258, -1, 1, 0, 1},
             '{8'h02, 24'h040000, 2, 43, 1, 0, 0}, '{8'h02, 24'h050000, 2, 20, 1, 0, 0},
             '{8'h02, 24'h060000, 0, -1, 1, 0, 0}, '{8'h02, 24'h070000, 1, -1, 0, 0, 0},
             '{8'h02, 24'h000200, 2, -1, 1, 1, 0}};
    step(6);
    rst = 1'h0;
    step(4);
    chk("reset flags", 0, {write_enable_latch, busy, err, soOe});
    // Table rows: each page is compared whole against the expected image
    foreach (rows[i]) begin
      r = rows[i];
      prot = r.pr;
      if (r.wl) set_wel();
      bsy = 0;
      u_host.frame(r.opc, r.adr, r.n, 8'(i * 16 + 1), r.cut);
      settle();
      for (int k = 0; k < 256; k++) ep[k] = 8'hff;
      for (int k = 0; k < r.n && r.ok; k++) ep[8'(r.adr[7:0] + k)] = 8'(i * 16 + 1 + k + (k >> 8));
      for (int k = 0; k < 256; k++) chk("page byte", ep[k], mem[idx({r.adr[23:8], 8'(k)})]);
      p = r.n == 1 ? BP : PP;
      if (r.ok) chk("busy span", 1, bsy + 8 >= p && bsy <= p + 8);
      else chk("no launch", 0, bsy);
      chk("latch after", 0, write_enable_latch);
    end
    // Latch set, then dropped by the clear pulse
    set_wel();
    chk("latch set", 1, write_enable_latch);
    welClr = 1'h1;
    step(1);
    welClr = 1'h0;
    step(2);
    chk("latch clear", 0, write_enable_latch);
    // Status poll in mid-program, then the active status line
    set_wel();
    u_host.frame(8'h02, 24'h010100, 2, 8'h33, -1);
    step(30);
    u_host.cmd(8'h05, 16);
    u_host.stop();
    chk("status", 8'h01, u_host.rx);
    u_host.cmd(8'h25, 16);
    step(4);
    chk("asi busy", 1, soIn);
    for (int t = 0; t < 3000 && soIn !== 1'h0; t++) step(1);
    step(2);
    chk("asi done", 0, {soIn, busy});
    u_host.stop();
    // A byte that is not erased keeps its zeros and the error flag rises
    mem[idx(24'h070010)] = 8'h0f;
    set_wel();
    u_host.frame(8'h02, 24'h070010, 1, 8'hf0, -1);
    settle();
    chk("merged byte", 8'h00, mem[idx(24'h070010)]);
    chk("error flag", 1, err);
    // Reset in mid-program returns every flag to idle
    set_wel();
    u_host.frame(8'h02, 24'h050040, 2, 8'h44, -1);
    for (int t = 0; t < 100 && busy !== 1'h1; t++) step(1);
    rst = 1'h1;
    step(2);
    rst = 1'h0;
    step(1);
    chk("reset mid run", 0, {write_enable_latch, busy, err, soOe, aWe});
    final_report();
  end
endmodule // test_spi_flash_page_program
`default_nettype wire
